// >>> dv/lcd_panel_model.sv
module lcd_panel_model
	import lcd_pkg::*;
(
	input wire logic             clk_sys,
	input wire logic [47:0]      segOut,
	input wire logic [3:0]       comOut,
	output logic     [3:0][47:0] litMap
);
	timeunit 1ns;
	timeprecision 1ps;
	// the glass latches the segment row of whichever plate is driven
	always @(posedge clk_sys)
		for (int c = 0; c < LCD_COM_COUNT; c++)
			if (comOut[c]) litMap[c] <= segOut;
endmodule // lcd_panel_model

// >>> dv/lcd_segment_controller_tb.sv
module lcd_segment_controller_tb
	import lcd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic             clk_sys = 0, rst_n = 0, standbyOsc = 0, haltReq = 0, auxRun = 0;
	logic             busWr = 0, busRd = 0, displayOn;
	logic [7:0]       busAddr = 8'h00, busWdata = 8'h00, busRdata;
	logic [47:0]      segOut;
	logic [3:0]       comOut;
	logic [3:0][47:0] litMap;
	int               errorCnt = 0, checked = 0, n;
	// 50 MHz system clock; standby oscillator runs fast to keep slots short
	always #10 clk_sys = ~clk_sys;
	always #200 if (auxRun) standbyOsc = ~standbyOsc;
	lcd_segment_controller lcd_segment_controller_i (.clk_sys(clk_sys), .rst_n(rst_n),
		.standbyOsc(standbyOsc), .haltReq(haltReq), .busWr(busWr), .busRd(busRd),
		.busAddr(busAddr), .busWdata(busWdata), .busRdata(busRdata), .segOut(segOut),
		.comOut(comOut), .displayOn(displayOn));
	lcd_panel_model lcd_panel_model_i (.clk_sys(clk_sys), .segOut(segOut), .comOut(comOut),
		.litMap(litMap));
	function automatic logic [7:0] pat(int g, int k);
		return 8'(8'ha5 ^ ((g * 6 + k) * 8'h1d));
	endfunction
	// unused low bits of each plate's first byte never reach a segment
	function automatic logic [47:0] row(int g);
		logic [47:0] v;
		for (int k = 0; k < 6; k++) v[8*k+:8] = pat(g, k);
		v[2:0] = 3'h0;
		return v;
	endfunction
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checked, errorCnt);
		if (errorCnt == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		checked++;
		if (got !== exp) $display("wrong value at %0t: got %h expected %h", $time, got, exp);
		if (got !== exp) errorCnt++;
	endtask
	// one strobe per access, released a full cycle later
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		{busWr, busAddr, busWdata} = {1'b1, a, d};
		@(negedge clk_sys);
		busWr = 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_sys);
		{busRd, busAddr} = {1'b1, a};
		@(negedge clk_sys);
		busRd = 0;
		chk(48'(busRdata), 48'(exp));
	endtask
	// bounded wait on the common lines (sel=1) or on the run flag (sel=0)
	task automatic waitFor(input int sel, input logic [3:0] v, input int lim);
		for (n = 0; (sel ? comOut : {3'h0, displayOn}) !== v && n < lim; n++)
			@(negedge clk_sys);
		if (n >= lim) $display("wrong value at %0t: wait ran out", $time);
		if (n >= lim) errorCnt++;
		if (n >= lim) wrap_up();
	endtask
	task automatic scanTest();
		logic [47:0] r0;
		for (int g = 0; g < 4; g++)
			for (int k = 0; k < 6; k++) wr(8'(8'he0 + 6 * g + k), pat(g, k));
		wr(LCD_MODE_ADDR, 8'h9e);
		rd(LCD_MODE_ADDR, 8'h9e);
		rd(8'h10, 8'h00);
		wr(8'h11, 8'hff);
		rd(8'h11, 8'h00);
		rd(8'hf3, pat(3, 1));
		waitFor(1, 4'h1, 20);
		chk(segOut, row(0));
		waitFor(1, 4'h2, 5000);
		chk(segOut, row(1));
		wr(8'he1, 8'h3c);
		for (n = 2; comOut === 4'h2 && n < 5000; n++) @(negedge clk_sys);
		chk(48'(n), 48'd2048);
		chk(48'(comOut), 48'h1);
		chk(litMap[1], row(1));
		r0 = row(0);
		chk(segOut, {r0[47:16], 8'h3c, r0[7:0]});
		$display("scan test done");
	endtask
	task automatic haltTest();
		haltReq = 1;
		waitFor(0, 4'h0, 8);
		chk(segOut, 48'h0);
		chk(48'(comOut), 48'h0);
		haltReq = 0;
		$display("halt test done");
	endtask
	// off and both reserved clock codes must blank by frame end
	task automatic offTest();
		logic [2:0] codes[3] = '{LCD_CLK_OFF, LCD_CLK_RSV0, LCD_CLK_RSV1};
		wr(LCD_MODE_ADDR, 8'h9f);
		@(negedge clk_sys);
		chk(segOut, 48'h0);
		chk(48'(comOut), 48'h0);
		foreach (codes[i])
		begin
			wr(LCD_MODE_ADDR, 8'h9e);
			waitFor(0, 4'h1, 100);
			wr(LCD_MODE_ADDR, {2'h2, codes[i], 3'h6});
			waitFor(0, 4'h0, 9000);
			chk(segOut, 48'h0);
			chk(48'(comOut), 48'h0);
		end
		$display("off test done");
	endtask
	// aux code with a silent oscillator: supervisor must ground the panel
	task automatic failTest();
		wr(LCD_MODE_ADDR, 8'h8e);
		waitFor(0, 4'h1, 100);
		waitFor(0, 4'h0, 4200);
		chk(48'(comOut), 48'h0);
		$display("fail test done");
	endtask
	task automatic auxTest();
		auxRun = 1;
		wr(LCD_MODE_ADDR, 8'h8e);
		repeat (9000) @(negedge clk_sys);
		haltReq = 1;
		waitFor(1, 4'h1, 3000);
		waitFor(1, 4'h2, 3000);
		chk(48'(displayOn), 48'h1);
		haltReq = 0;
		$display("aux test done");
	endtask
	initial
	begin
		repeat (10) @(negedge clk_sys);
		rst_n = 1;
		scanTest();
		haltTest();
		offTest();
		failTest();
		auxTest();
		wrap_up();
	end
endmodule // lcd_segment_controller_tb

// >>> rtl/lcd_pkg.sv
// Behaviour
// - each display RAM bit, except the low three of each first byte, drives one segment/common element; set means on
// - display RAM is never cleared or loaded by reset
// - RAM of unused commons is plain storage with no display effect
// - RAM at E0..F7, six bytes per common; low three bits of first byte unused
// - halt while on main clock switches off and grounds every line
// - auxiliary oscillator code keeps the display running through halt
// - clock source change applies only at frame end; software waits before halt
// - clock select 000 blanks, 001 auxiliary oscillator, 010 and 111 reserved, others divide main clock
// - mode control register at DC: mux 7-6, clock 5-3, frame 2-0
// - mux field sets how many commons are scanned, one to four
// - frame field divides 32 kHz by 512,386,256,192,128,96,64; 111 reserved
// - mux code 00 four, 01 one, 10 two, 11 three commons
// - clock codes 011..110 divide main clock by 32,64,128,256
// - frame rate is base rate over active commons
// - oscillator failure grounds every segment and common line; code grounds them for one cycle only, then the scan restarts
package lcd_pkg;
	localparam logic [7:0] LCD_MODE_ADDR   = 8'hdc;
	localparam logic [7:0] LCD_RAM_FIRST   = 8'he0;
	localparam logic [7:0] LCD_RAM_LAST    = 8'hf7;
	localparam int         LCD_RAM_BYTES   = 24;
	localparam int         LCD_GROUP_BYTES = 6;
	localparam int         LCD_SEG_COUNT   = 48;
	localparam int         LCD_COM_COUNT   = 4;
	localparam int         LCD_MUX_MSB     = 7;
	localparam int         LCD_MUX_LSB     = 6;
	localparam int         LCD_CLK_MSB     = 5;
	localparam int         LCD_CLK_LSB     = 3;
	localparam int         LCD_FRM_MSB     = 2;
	localparam int         LCD_FRM_LSB     = 0;
	localparam logic [7:0] LCD_MODE_RESET  = 8'h00;
	localparam logic [2:0] LCD_CLK_OFF     = 3'h0;
	localparam logic [2:0] LCD_CLK_AUX     = 3'h1;
	localparam logic [2:0] LCD_CLK_RSV0    = 3'h2;
	localparam logic [2:0] LCD_CLK_RSV1    = 3'h7;
	localparam logic [2:0] LCD_FRM_RSV     = 3'h7;
	// missing-edge watchdog on the selected reference, in sys clocks
	localparam logic [11:0] LCD_FAIL_LIMIT = 12'hfff;
	typedef enum logic [1:0] {LCD_OFF, LCD_RUN} lcd_state_t;
endpackage

// >>> rtl/lcd_segment_controller.sv
module lcd_segment_controller
	import lcd_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        standbyOsc,
	input  wire logic        haltReq,
	input  wire logic        busWr,
	input  wire logic        busRd,
	input  wire logic [7:0]  busAddr,
	input  wire logic [7:0]  busWdata,
	output logic      [7:0]  busRdata,
	output logic      [47:0] segOut,
	output logic      [3:0]  comOut,
	output logic             displayOn
);
	// display RAM is an array, no reset term at all
	logic [7:0] ramMem [LCD_RAM_BYTES];

	typedef struct packed {
		lcd_state_t  st;
		logic [7:0]  mode;
		logic [2:0]  clkAct;
		logic [2:0]  auxSync;
		logic        auxLvl;
		logic [7:0]  refDiv;
		logic        refTick;
		logic [9:0]  frmCnt;
		logic [1:0]  comIdx;
		logic [11:0] failCnt;
		logic [7:0]  rdata;
		logic [47:0] seg;
		logic [3:0]  com;
		logic        on;
	} lcd_reg_t;

	lcd_reg_t r_q;
	lcd_reg_t r_d;

	// number of scanned commons for a multiplex code
	function automatic logic [2:0] activeComs(input logic [1:0] mux);
		unique case (mux)
			2'b00: activeComs = 3'd4;
			2'b01: activeComs = 3'd1;
			2'b10: activeComs = 3'd2;
			2'b11: activeComs = 3'd3;
		endcase
	endfunction

	// reference ticks per common slot; zero marks the reserved code
	function automatic logic [9:0] baseDiv(input logic [2:0] f);
		unique case (f)
			3'h0: baseDiv = 10'd512;
			3'h1: baseDiv = 10'd386;
			3'h2: baseDiv = 10'd256;
			3'h3: baseDiv = 10'd192;
			3'h4: baseDiv = 10'd128;
			3'h5: baseDiv = 10'd96;
			3'h6: baseDiv = 10'd64;
			3'h7: baseDiv = 10'd0;
		endcase
	endfunction

	// main clock prescale for the nominal 32 kHz reference
	function automatic logic [8:0] mainDiv(input logic [2:0] c);
		unique case (c)
			3'h3: mainDiv = 9'd32;
			3'h4: mainDiv = 9'd64;
			3'h5: mainDiv = 9'd128;
			3'h6: mainDiv = 9'd256;
			default: mainDiv = 9'd0;
		endcase
	endfunction

	// reserved codes are treated like the off code
	function automatic logic clkUsable(input logic [2:0] c);
		clkUsable = (c != LCD_CLK_OFF) && (c != LCD_CLK_RSV0) && (c != LCD_CLK_RSV1);
	endfunction

	logic       ramHit;
	logic [4:0] ramIdx;
	logic [4:0] scanBase;
	logic [7:0] scanByte [LCD_GROUP_BYTES];
	logic [47:0] rowBits;

	// byte index for cpu access and for the common being scanned
	always_comb
	begin
		ramHit   = (busAddr >= LCD_RAM_FIRST) && (busAddr <= LCD_RAM_LAST);
		ramIdx   = 5'(busAddr - LCD_RAM_FIRST);
		scanBase = 5'(r_q.comIdx) * 5'd6;
		for (int i = 0; i < LCD_GROUP_BYTES; i++)
			scanByte[i] = ramMem[5'(scanBase + 5'(i))];
		rowBits = {scanByte[5], scanByte[4], scanByte[3], scanByte[2], scanByte[1],
		           scanByte[0][7:3], 3'b000};
	end

	// ram writes; scan reads the array live, so updates reach the pins even mid slot
	always_ff @(posedge clk_sys)
	begin
		if (busWr && ramHit)
			ramMem[ramIdx] <= busWdata;
	end

	logic       auxRise;
	logic       pending;
	logic [2:0] nComs;
	logic [9:0] fdiv;

	always_comb
	begin
		r_d = r_q;
		nComs = activeComs(r_q.mode[LCD_MUX_MSB:LCD_MUX_LSB]);
		fdiv  = baseDiv(r_q.mode[LCD_FRM_MSB:LCD_FRM_LSB]);
		// standby oscillator pin: three stages, edge once second and third agree
		r_d.auxSync = {r_q.auxSync[1:0], standbyOsc};
		auxRise = 1'b0;
		if (r_q.auxSync[2] == r_q.auxSync[1] && r_q.auxSync[2] != r_q.auxLvl)
		begin
			r_d.auxLvl = r_q.auxSync[2];
			auxRise = r_q.auxSync[2];
		end
		// register write and readback
		if (busWr && busAddr == LCD_MODE_ADDR)
			r_d.mode = busWdata;
		if (busRd)
			r_d.rdata = (busAddr == LCD_MODE_ADDR) ? r_q.mode
			          : (ramHit ? ramMem[ramIdx] : 8'h00);
		// reference tick: main clock divider or aux edge
		r_d.refTick = 1'b0;
		if (r_q.clkAct == LCD_CLK_AUX)
			r_d.refTick = auxRise;
		else if (clkUsable(r_q.clkAct))
		begin
			r_d.refDiv = r_q.refDiv + 8'h01;
			if (9'(r_q.refDiv) + 9'd1 >= mainDiv(r_q.clkAct))
			begin
				r_d.refDiv = 8'h00;
				r_d.refTick = 1'b1;
			end
		end
		// oscillator supervisor: no reference for too long means failure
		if (r_q.refTick || r_q.st == LCD_OFF)
			r_d.failCnt = 12'h000;
		else if (r_q.failCnt != LCD_FAIL_LIMIT)
			r_d.failCnt = r_q.failCnt + 12'h001;
		// a new clock code waits for the scan to wrap, so no frame is cut short
		pending = r_q.mode[LCD_CLK_MSB:LCD_CLK_LSB] != r_q.clkAct;
		unique case (r_q.st)
			LCD_OFF:
			begin
				// track the written code while stopped
				r_d.clkAct = r_q.mode[LCD_CLK_MSB:LCD_CLK_LSB];
				r_d.frmCnt = 10'd0;
				r_d.comIdx = 2'd0;
				if (clkUsable(r_d.clkAct) && !haltReq)
					r_d.st = LCD_RUN;
				else if (clkUsable(r_d.clkAct) && r_d.clkAct == LCD_CLK_AUX)
					r_d.st = LCD_RUN;
			end
			LCD_RUN:
			begin
				if (r_q.refTick && fdiv != 10'd0)
				begin
					r_d.frmCnt = r_q.frmCnt + 10'd1;
					if (r_q.frmCnt + 10'd1 >= fdiv)
					begin
						r_d.frmCnt = 10'd0;
						if (3'(r_q.comIdx) + 3'd1 >= nComs)
						begin
							r_d.comIdx = 2'd0;
							if (pending)
								r_d.clkAct = r_q.mode[LCD_CLK_MSB:LCD_CLK_LSB];
						end
						else
							r_d.comIdx = r_q.comIdx + 2'd1;
					end
				end
				// mux shrink mid frame: restart the scan at the first common
				if (3'(r_q.comIdx) >= nComs)
					r_d.comIdx = 2'd0;
				if (haltReq && r_q.clkAct != LCD_CLK_AUX)
					r_d.st = LCD_OFF;
				if (!clkUsable(r_q.clkAct) || r_q.failCnt == LCD_FAIL_LIMIT)
					r_d.st = LCD_OFF;
			end
			default: r_d.st = LCD_OFF;
		endcase
		// pin drive: active common high, its row on segments, else all ground
		r_d.on = (r_q.st == LCD_RUN);
		if (r_q.st == LCD_RUN && fdiv != 10'd0)
		begin
			r_d.com = 4'h1 << r_q.comIdx;
			r_d.seg = rowBits;
		end
		else
		begin
			r_d.com = 4'h0;
			r_d.seg = '0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			// display ram sits outside this struct, so reset never touches it
			r_q      <= '0;
			r_q.st   <= LCD_OFF;
			r_q.mode <= LCD_MODE_RESET;
		end
		else
			r_q <= r_d;
	end

	assign busRdata  = r_q.rdata;
	assign segOut    = r_q.seg;
	assign comOut    = r_q.com;
	assign displayOn = r_q.on;

	// checks: outputs lag the state by one edge, so blanking that needs a state change is looked at two edges on

	// halt on the main clock grounds every line
	a_halt_blanks: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(r_q.st == LCD_RUN && haltReq && r_q.clkAct != LCD_CLK_AUX)
		|-> ##2 (comOut == 4'h0 && segOut == '0))
		else $error("halt on main clock did not blank");

	// off code requested and active: commons grounded
	a_off_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(r_q.clkAct == LCD_CLK_OFF && r_q.mode[LCD_CLK_MSB:LCD_CLK_LSB] == LCD_CLK_OFF)
		|-> ##2 (comOut == 4'h0))
		else $error("clock off but commons driven");

	// the driven common is the one scanned an edge before
	a_com_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(comOut != 4'h0) |-> (comOut == (4'h1 << $past(r_q.comIdx))))
		else $error("common out of range");

	// never two commons at once
	a_one_com: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$onehot0(comOut))
		else $error("more than one common active");

	// scan index stays inside the active commons
	a_scan_limit: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(3'(r_q.comIdx) < activeComs(r_q.mode[LCD_MUX_MSB:LCD_MUX_LSB])
		 || r_q.st == LCD_OFF || $changed(r_q.mode)))
		else $error("scan index beyond active commons");

	// a new source is only taken when the scan is back at the first common
	a_src_frame: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(r_q.st == LCD_RUN && $changed(r_q.clkAct)) |-> r_q.comIdx == 2'd0
		|| $past(r_q.st) == LCD_OFF)
		else $error("clock source changed mid frame");

	// supervisor timeout grounds the commons
	a_fail_blank: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(r_q.st == LCD_RUN && r_q.failCnt == LCD_FAIL_LIMIT) |-> ##2 (comOut == 4'h0))
		else $error("oscillator failure not blanked");

	// mode register takes every write
	a_mode_rw: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(busWr && busAddr == LCD_MODE_ADDR) |=> (r_q.mode == $past(busWdata)))
		else $error("mode register write lost");

	// low three bits of each first byte never reach a pin
	a_na_bits: assert property (@(posedge clk_sys) disable iff (!rst_n)
		segOut[2:0] == 3'b000)
		else $error("unavailable segment bits driven");

	// unmapped reads return zero
	a_rd_unmapped: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(busRd && !ramHit && busAddr != LCD_MODE_ADDR) |=> (busRdata == 8'h00))
		else $error("unmapped read not zero");

	// mode readback shows the register
	a_rd_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(busRd && busAddr == LCD_MODE_ADDR) |=> (busRdata == $past(r_q.mode)))
		else $error("mode readback wrong");

	// read data holds until the next read
	a_rdata_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!busRd |=> $stable(busRdata))
		else $error("read data moved without a read");

	// aux source keeps running through halt
	a_aux_halt: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(r_q.st == LCD_RUN && r_q.clkAct == LCD_CLK_AUX && haltReq
		 && r_q.failCnt != LCD_FAIL_LIMIT) |=> (r_q.st == LCD_RUN))
		else $error("aux display stopped at halt");

	// no restart while halted on the main clock
	a_halt_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(r_q.st == LCD_OFF && haltReq && r_q.mode[LCD_CLK_MSB:LCD_CLK_LSB] != LCD_CLK_AUX)
		|=> (r_q.st == LCD_OFF))
		else $error("restarted during halt");

	// reserved frame code leaves the panel grounded
	a_frm_rsv: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(r_q.mode[LCD_FRM_MSB:LCD_FRM_LSB] == LCD_FRM_RSV)
		|=> (comOut == 4'h0 && segOut == '0))
		else $error("reserved frame code drives panel");

	// stopped controller grounds every line
	a_off_ground: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(r_q.st == LCD_OFF) |=> (comOut == 4'h0 && segOut == '0))
		else $error("stopped controller drives panel");
endmodule // lcd_segment_controller
